// >>> logic/idc_command_port.sv
// i2c target command interpreter for dsp memories, registers and readback
// Summary of operation
// RQ1: fields after first byte travel as bytes, msb first, ack after each
// RQ2: write is address, command byte, then bytes that command needs
// RQ3: 80h-8Fh prepare coefficient write, 2-byte address, low nibble+1 words
// RQ4: words beyond the prepared count are discarded
// RQ5: 90h-9Fh prepare offset write the same way
// RQ6: A4h/A2h execute prepared write; address ignored, no data
// RQ7: in reset B4h/B2h write coefficient/offset memory, 2-byte words
// RQ8: in reset B8h writes program memory with 5-byte words
// RQ9: C0h-CFh write control register, F4h writes jump code, one byte
// RQ10: further written words go to next sequential address
// RQ11: read is write phase with command, then repeated start and read
// RQ12: keep sending bytes while controller acks; release after nack
// RQ13: controller nacks last byte before stop
// RQ14: in reset 34h/32h read coefficient/offset memory, 2-byte words
// RQ15: in reset 38h reads program memory, 5-byte words
// RQ16: 40h-4Fh read control register, 60h reads device id, one byte
// RQ17: 76h/78h return 28 data bits then 4 flag bits, four bytes
// RQ18: read address without valid read command is nacked
// RQ19: ready rising between write and read address nacks read address
// RQ20: controller should poll acknowledge before read address
// RQ21: further read words come from sequential addresses
// RQ22: address is fixed five bits plus two select pins, bit 0 is direction
// RQ23: target address and every written byte are acknowledged
// RQ24: controller prepares before executing a run-time write
// RQ25: unknown commands change nothing
module idc_command_port
  import idc_pkg::*;
#(
  parameter int PREP_MAX = 16
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic        addr_select_hi_pin_in,
  input  wire logic        addr_select_lo_pin_in,
  input  wire logic        sys_reset_in,
  input  wire logic        ready_in,
  input  wire logic [39:0] mem_rdata_in,
  input  wire logic [31:0] readback_word_a_in,
  input  wire logic [31:0] readback_word_b_in,
  output logic             mem_we_out,
  output logic [1:0]       mem_sel_out,
  output logic [15:0]      mem_addr_out,
  output logic [39:0]      mem_wdata_out,
  output logic             exec_coef_out,
  output logic             exec_offs_out,
  output logic [7:0]       external_jump_code_out,
  output logic [7:0]       ctrl_reg_out [16]
);
  typedef struct packed {
    logic [1:0]  scl_s;
    logic [1:0]  sda_s;
    logic        scl_d;
    logic        sda_d;
    logic        rdy_d;
    idc_state_t  st;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic        is_rd;
    logic        first;
    logic [7:0]  cmd;
    logic [3:0]  idx;
    logic [2:0]  wbytes;
    logic [39:0] wbuf;
    logic [15:0] maddr;
    logic        rd_ok;
    logic        oe;
    logic        acked;
    logic [4:0]  left;
    logic        we;
    logic        exc;
    logic        exo;
    logic [7:0]  jump;
  } idc_state_s_t;

  idc_state_s_t s, next_s;
  logic [7:0] regs [16];
  logic [7:0] next_regs [16];
  logic       scl_rise, scl_fall, start_c, stop_c;

  // bytes per word for a command's memory; 5 for program commands, 2 for all others
  function automatic logic [2:0] word_len(input logic [7:0] c);
    if (c == IDC_CMD_PWR || c == IDC_CMD_PRD) word_len = 3'(IDC_PRG_BYTES);
    else word_len = 3'(IDC_WORD_BYTES);
  endfunction

  function automatic idc_mem_t mem_of(input logic [7:0] c);
    mem_of = IDC_MEM_NONE;
    if (c[7:4] == IDC_CMD_CWPREP[7:4] || c == IDC_CMD_CWR || c == IDC_CMD_CRD)
      mem_of = IDC_MEM_COEF;
    if (c[7:4] == IDC_CMD_OWPREP[7:4] || c == IDC_CMD_OWR || c == IDC_CMD_ORD)
      mem_of = IDC_MEM_OFFS;
    if (c == IDC_CMD_PWR || c == IDC_CMD_PRD) mem_of = IDC_MEM_PROG;
  endfunction

  function automatic logic [7:0] tx_byte(input logic [7:0] c, input logic [3:0] i,
                                         input logic [39:0] w, input logic [7:0] r,
                                         input logic [31:0] ra, input logic [31:0] rb);
    tx_byte = 8'hFF;
    // single-byte reads pad with all ones once their byte has gone out
    if (c[7:4] == IDC_CMD_REGRD[7:4] && i == 4'h0) tx_byte = r; //RQ16
    else if (c == IDC_CMD_IDRD && i == 4'h0) tx_byte = IDC_DEVICE_ID; //RQ16
    else if (c == IDC_CMD_RBARD && i < 4'(IDC_RB_BYTES)) tx_byte = ra[31 - 8*i -: 8]; //RQ17
    else if (c == IDC_CMD_RBBRD && i < 4'(IDC_RB_BYTES)) tx_byte = rb[31 - 8*i -: 8]; //RQ17
    else if (c == IDC_CMD_PRD) tx_byte = w[39 - 8*i -: 8]; //RQ15
    else if (c == IDC_CMD_CRD || c == IDC_CMD_ORD) tx_byte = w[15 - 8*i -: 8]; //RQ14
  endfunction

  assign scl_rise = s.scl_s[1] & ~s.scl_d;
  assign scl_fall = ~s.scl_s[1] & s.scl_d;
  assign start_c  = s.scl_s[1] & s.scl_d & s.sda_d & ~s.sda_s[1];
  assign stop_c   = s.scl_s[1] & s.scl_d & ~s.sda_d & s.sda_s[1];

  always_comb begin
    logic [7:0] b;
    logic       is_mem_cmd;
    b = {s.sh[6:0], s.sda_s[1]};
    is_mem_cmd = 1'b0;
    next_s = s;
    next_regs = regs;
    next_s.scl_s = {s.scl_s[0], scl_in};
    next_s.sda_s = {s.sda_s[0], sda_in};
    next_s.scl_d = s.scl_s[1];
    next_s.sda_d = s.sda_s[1];
    next_s.rdy_d = ready_in;
    next_s.we  = 1'b0;
    next_s.exc = 1'b0;
    next_s.exo = 1'b0;
    if (start_c) begin
      next_s.st = IDC_ST_ADDR;
      next_s.bitn = 4'h0;
      next_s.oe = 1'b0;
    end else if (stop_c) begin
      next_s.st = IDC_ST_IDLE;
      next_s.oe = 1'b0;
    end else begin
      case (s.st)
        IDC_ST_IDLE: next_s.oe = 1'b0;
        IDC_ST_ADDR, IDC_ST_RX: begin
          if (scl_rise) begin
            next_s.sh = b; //RQ1
            next_s.bitn = s.bitn + 4'h1;
          end
          if (scl_fall && s.bitn == 4'(IDC_BYTE_BITS)) begin
            next_s.bitn = 4'h0;
            next_s.st = IDC_ST_SKIP;
            if (s.st == IDC_ST_ADDR) begin
              if (s.sh[7:3] == IDC_ADDR_FIXED && //RQ22
                  s.sh[2:1] == {addr_select_hi_pin_in, addr_select_lo_pin_in} &&
                  (!s.sh[0] || s.rd_ok)) begin //RQ18
                next_s.st = IDC_ST_ACK;
                next_s.oe = 1'b1; //RQ23
                next_s.is_rd = s.sh[0];
                next_s.first = 1'b1;
                if (!s.sh[0]) next_s.rd_ok = 1'b0;
                next_s.idx = 4'h0;
                if (s.sh[0]) next_s.wbuf = mem_rdata_in;
              end
            end else begin
              next_s.st = IDC_ST_ACK;
              next_s.oe = 1'b1; //RQ23
              if (s.first) begin //RQ2
                next_s.cmd = s.sh;
                next_s.first = 1'b0;
                next_s.idx = 4'h0;
                next_s.wbytes = 3'h0;
                next_s.left = 5'({1'b0, s.sh[3:0]}) + 5'h1; //RQ3 RQ5
                next_s.rd_ok = (s.sh[7:4] == IDC_CMD_REGRD[7:4]) || //RQ11 RQ16
                               s.sh == IDC_CMD_IDRD || s.sh == IDC_CMD_RBARD ||
                               s.sh == IDC_CMD_RBBRD;
              end else begin
                is_mem_cmd = mem_of(s.cmd) != IDC_MEM_NONE;
                if (s.idx < 4'h2 && (is_mem_cmd || s.cmd == IDC_CMD_CWEXEC ||
                                     s.cmd == IDC_CMD_OWEXEC)) begin
                  next_s.maddr = {s.maddr[7:0], s.sh};
                  next_s.idx = s.idx + 4'h1;
                  if (s.idx == 4'h1) begin
                    // memory reads are only served while the dsp is held in reset
                    next_s.rd_ok = sys_reset_in && (s.cmd == IDC_CMD_CRD ||
                                   s.cmd == IDC_CMD_ORD || s.cmd == IDC_CMD_PRD); //RQ14 RQ15
                    next_s.exc = s.cmd == IDC_CMD_CWEXEC; //RQ6
                    next_s.exo = s.cmd == IDC_CMD_OWEXEC; //RQ6
                    if (s.cmd == IDC_CMD_CWEXEC || s.cmd == IDC_CMD_OWEXEC)
                      next_s.maddr = s.maddr;
                  end
                end else if (s.cmd[7:4] == IDC_CMD_REGWR[7:4] && s.idx == 4'h0) begin
                  next_regs[s.cmd[3:0]] = s.sh; //RQ9
                  next_s.idx = 4'h1;
                end else if (s.cmd == IDC_CMD_JUMPWR && s.idx == 4'h0) begin
                  next_s.jump = s.sh; //RQ9
                  next_s.idx = 4'h1;
                // stray bytes after a read command must never reach memory
                end else if (is_mem_cmd && ((s.cmd[7:5] == 3'h5 && sys_reset_in) || //RQ7 RQ8
                                            (s.cmd[7:5] == 3'h4 && s.left != 5'h0))) begin
                  next_s.wbuf = {s.wbuf[31:0], s.sh}; //RQ7 RQ8
                  next_s.wbytes = s.wbytes + 3'h1;
                  if (s.wbytes + 3'h1 == word_len(s.cmd)) begin
                    next_s.wbytes = 3'h0;
                    next_s.we = 1'b1;
                    if (s.cmd[7:5] == 3'h4) next_s.left = s.left - 5'h1; //RQ4
                  end
                end //RQ25
              end
            end
          end
        end
        IDC_ST_ACK: begin
          if (scl_fall) begin
            next_s.oe = 1'b0;
            next_s.st = IDC_ST_RX;
            if (s.is_rd) begin
              next_s.st = IDC_ST_TX;
              next_s.sh = tx_byte(s.cmd, s.idx, s.wbuf, regs[s.cmd[3:0]],
                                  readback_word_a_in, readback_word_b_in);
              next_s.oe = ~next_s.sh[7];
            end
          end
        end
        IDC_ST_TX: begin
          if (scl_fall) begin //RQ1
            next_s.bitn = s.bitn + 4'h1;
            next_s.sh = {s.sh[6:0], 1'b1};
            next_s.oe = ~s.sh[6];
            if (s.bitn == 4'(IDC_BYTE_BITS - 1)) begin
              next_s.oe = 1'b0;
              next_s.st = IDC_ST_MACK;
              next_s.bitn = 4'h0;
            end
          end
        end
        IDC_ST_MACK: begin
          if (scl_rise) next_s.acked = ~s.sda_s[1];
          if (scl_fall) begin
            if (s.acked) begin //RQ12
              next_s.idx = s.idx + 4'h1;
              if (mem_of(s.cmd) != IDC_MEM_NONE) begin
                // read data follows the address combinationally, so the address steps
                // while the last byte of a word goes out and the word loads at the boundary
                if (s.idx + 4'h2 == 4'(word_len(s.cmd))) begin //RQ21
                  next_s.maddr = s.maddr + 16'h1;
                end
                if (s.idx + 4'h1 == 4'(word_len(s.cmd))) begin //RQ21
                  next_s.idx = 4'h0;
                  next_s.wbuf = mem_rdata_in;
                end
              end
              next_s.st = IDC_ST_TX;
              next_s.sh = tx_byte(s.cmd, next_s.idx, next_s.wbuf, regs[s.cmd[3:0]],
                                  readback_word_a_in, readback_word_b_in);
              next_s.oe = ~next_s.sh[7];
            end else begin
              next_s.st = IDC_ST_SKIP;
            end
          end
        end
        IDC_ST_SKIP: next_s.oe = 1'b0;
        default: next_s.st = IDC_ST_IDLE;
      endcase
    end
    // a ready rise outranks a read command taken in the same cycle
    if (ready_in & ~s.rdy_d) next_s.rd_ok = 1'b0; //RQ19
    if (s.we) next_s.maddr = s.maddr + 16'h1; //RQ10
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1, st: IDC_ST_IDLE,
             default: '0};
      regs <= '{default: 8'h00};
    end else begin
      s <= next_s;
      regs <= next_regs;
    end
  end

  assign sda_out       = 1'b0;
  assign sda_oe_out    = s.oe;
  assign mem_we_out    = s.we;
  assign mem_sel_out   = mem_of(s.cmd);
  assign mem_addr_out  = s.maddr;
  assign mem_wdata_out = s.wbuf;
  assign exec_coef_out = s.exc;
  assign exec_offs_out = s.exo;
  assign external_jump_code_out = s.jump;
  assign ctrl_reg_out  = regs;

  AST_NACK_BAD_READ: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) //RQ18
    (s.st == IDC_ST_ADDR && scl_fall && s.bitn == 4'h8 && s.sh[0] && !s.rd_ok)
    |=> !s.oe) else $error("read address acked without read command");
  AST_READY_RISE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) //RQ19
    (ready_in && !s.rdy_d) |=> !s.rd_ok) else $error("ready rise kept read enabled");
  AST_WORD_LIMIT: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) //RQ4
    (s.cmd[7:5] == 3'h4 && s.left == 5'h0) |=> !s.we) else $error("extra word stored");
  AST_ADDR_STEP: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) //RQ10
    (s.we && !start_c) |=> s.maddr == $past(s.maddr) + 16'h1) else $error("no address step");
  AST_EXEC_PULSE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) //RQ6
    s.exc |=> !s.exc) else $error("execute strobe longer than one cycle");
  AST_ACK_RELEASE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) //RQ23
    (s.st == IDC_ST_ACK && scl_fall && !s.is_rd) |=> !s.oe) else $error("ack held");
  AST_MACK_FREE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) //RQ12
    (s.st == IDC_ST_MACK) |-> !s.oe) else $error("sda driven in controller ack");
  AST_STOP_IDLE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) //RQ13
    stop_c |=> (s.st == IDC_ST_IDLE && !s.oe)) else $error("stop not honoured");
  AST_PREP_COUNT: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) //RQ3 RQ5
    (s.we && s.cmd[7:5] == 3'h4) |-> s.left < 5'(PREP_MAX)) else $error("prepared count overrun");
  AST_RUN_NO_LOAD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) //RQ7 RQ8
    (s.we && s.cmd[7:5] == 3'h5) |-> $past(sys_reset_in)) else $error("load outside reset");
endmodule

// >>> shared/idc_pkg.sv
// constants and types shared by the i2c dsp command port
package idc_pkg;
  localparam logic [4:0] IDC_ADDR_FIXED   = 5'h06;
  localparam int         IDC_BYTE_BITS    = 8;
  localparam int         IDC_MEM_AW       = 16;
  localparam int         IDC_PRG_BYTES    = 5;
  localparam int         IDC_WORD_BYTES   = 2;
  localparam int         IDC_RB_BYTES     = 4;
  localparam logic [7:0] IDC_CMD_CWPREP   = 8'h80;
  localparam logic [7:0] IDC_CMD_OWPREP   = 8'h90;
  localparam logic [7:0] IDC_CMD_OWEXEC   = 8'hA2;
  localparam logic [7:0] IDC_CMD_CWEXEC   = 8'hA4;
  localparam logic [7:0] IDC_CMD_OWR      = 8'hB2;
  localparam logic [7:0] IDC_CMD_CWR      = 8'hB4;
  localparam logic [7:0] IDC_CMD_PWR      = 8'hB8;
  localparam logic [7:0] IDC_CMD_REGWR    = 8'hC0;
  localparam logic [7:0] IDC_CMD_JUMPWR   = 8'hF4;
  localparam logic [7:0] IDC_CMD_ORD      = 8'h32;
  localparam logic [7:0] IDC_CMD_CRD      = 8'h34;
  localparam logic [7:0] IDC_CMD_PRD      = 8'h38;
  localparam logic [7:0] IDC_CMD_REGRD    = 8'h40;
  localparam logic [7:0] IDC_CMD_IDRD     = 8'h60;
  localparam logic [7:0] IDC_CMD_RBARD    = 8'h76;
  localparam logic [7:0] IDC_CMD_RBBRD    = 8'h78;
  localparam logic [3:0] IDC_HI_MASK      = 4'hF;
  // arbitrary neutral identification value
  localparam logic [7:0] IDC_DEVICE_ID    = 8'h5A;

  // memory kind selected by a command
  typedef enum logic [1:0] {
    IDC_MEM_NONE = 2'h0,
    IDC_MEM_COEF = 2'h1,
    IDC_MEM_OFFS = 2'h2,
    IDC_MEM_PROG = 2'h3
  } idc_mem_t;

  typedef enum logic [6:0] {
    IDC_ST_IDLE = 7'h01,
    IDC_ST_ADDR = 7'h02,
    IDC_ST_ACK  = 7'h04,
    IDC_ST_RX   = 7'h08,
    IDC_ST_TX   = 7'h10,
    IDC_ST_MACK = 7'h20,
    IDC_ST_SKIP = 7'h40
  } idc_state_t;
endpackage

// >>> dv/idc_i2c_ctrl.sv
// i2c controller model that drives the command port from the far side of the bus
module idc_i2c_ctrl (
  output logic      scl_out,
  output logic      sda_drv_out,
  input  wire logic sda_line_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // scl stands high between frames; sda is released so the pull-up holds it
  initial begin
    scl_out     = 1'b1;
    sda_drv_out = 1'b1;
  end

  task automatic bit_out(input logic b);
    sda_drv_out = b;
    #40 scl_out = 1'b1;
    #80 scl_out = 1'b0;
    #40;
  endtask

  task automatic bit_in(output logic b);
    sda_drv_out = 1'b1;
    #40 scl_out = 1'b1;
    #40 b = sda_line_in;
    #40 scl_out = 1'b0;
    #40;
  endtask

  // serves as repeated start too: sda is raised while scl is still low
  task automatic start_c;
    sda_drv_out = 1'b1;
    #40 scl_out = 1'b1;
    #40 sda_drv_out = 1'b0;
    #40 scl_out = 1'b0;
    #40;
  endtask

  task automatic stop_c;
    sda_drv_out = 1'b0;
    #40 scl_out = 1'b1;
    #40 sda_drv_out = 1'b1;
    #80;
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    bit_in(a);
    ack = ~a;
  endtask

  task automatic recv(input logic last, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_in(b[i]);
    bit_out(last);
  endtask
endmodule

// >>> dv/testbench.sv
// self-checking bench for the i2c dsp command port
module testbench;
  import idc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] WA = {IDC_ADDR_FIXED, 2'b10, 1'b0};
  logic        core_clk_in  = 1'b0;
  logic        rst_n_in     = 1'b0;
  logic        sys_reset_in = 1'b1;
  logic        ready_in     = 1'b0;
  logic [31:0] rb_a         = 32'h0;
  logic [31:0] rb_b         = 32'h0;
  logic        scl, sda_drv, sda_line, sda_out, sda_oe_out, mem_we_out, exec_c, exec_o;
  logic [1:0]  mem_sel_out;
  logic [15:0] mem_addr_out;
  logic [39:0] mem_wdata_out, mem_rdata;
  logic [7:0]  jump, regs [16];
  logic [57:0] wq [$];
  int          n_errors = 0, check_count = 0, n_exc = 0, n_exo = 0;

  assign sda_line  = sda_drv & (sda_out | ~sda_oe_out);
  assign mem_rdata = {mem_addr_out, 8'h5C, ~mem_addr_out};
  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end

  idc_command_port u_idc_command_port (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .addr_select_hi_pin_in(1'b1),
    .addr_select_lo_pin_in(1'b0), .sys_reset_in(sys_reset_in), .ready_in(ready_in),
    .mem_rdata_in(mem_rdata), .readback_word_a_in(rb_a), .readback_word_b_in(rb_b),
    .mem_we_out(mem_we_out), .mem_sel_out(mem_sel_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .exec_coef_out(exec_c), .exec_offs_out(exec_o),
    .external_jump_code_out(jump), .ctrl_reg_out(regs));
  idc_i2c_ctrl u_idc_i2c_ctrl (.scl_out(scl), .sda_drv_out(sda_drv), .sda_line_in(sda_line));

  // 16-bit memories only define the low 16 bits of the write word
  always @(posedge core_clk_in) begin
    if (mem_we_out) wq.push_back({mem_sel_out, mem_addr_out,
                                  mem_sel_out == 2'h3 ? mem_wdata_out : {24'h0, mem_wdata_out[15:0]}});
    if (exec_c) n_exc++;
    if (exec_o) n_exo++;
  end

  task automatic chk(input logic [57:0] got, input logic [57:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] q [$]);
    logic a;
    u_idc_i2c_ctrl.start_c();
    u_idc_i2c_ctrl.send(WA, a);
    chk(a, 1'b1);
    foreach (q[i]) begin
      u_idc_i2c_ctrl.send(q[i], a);
      chk(a, 1'b1);
    end
    u_idc_i2c_ctrl.stop_c();
  endtask

  task automatic rd(input logic [7:0] q [$], input logic [7:0] e [$]);
    logic a;
    logic [7:0] b;
    u_idc_i2c_ctrl.start_c();
    u_idc_i2c_ctrl.send(WA, a);
    chk(a, 1'b1);
    foreach (q[i]) begin
      u_idc_i2c_ctrl.send(q[i], a);
      chk(a, 1'b1);
    end
    u_idc_i2c_ctrl.start_c();
    u_idc_i2c_ctrl.send(WA | 8'h01, a);
    chk(a, 1'b1);
    foreach (e[i]) begin
      u_idc_i2c_ctrl.recv(i == e.size() - 1, b);
      chk(b, e[i]);
    end
    u_idc_i2c_ctrl.stop_c();
    chk(sda_oe_out, 1'b0);
  endtask

  task automatic s_regs;
    for (int r = 0; r < 16; r++) wr('{IDC_CMD_REGWR | 8'(r), 8'(8'h11 * r + 3)});
    for (int r = 0; r < 16; r++) chk(regs[r], 8'(8'h11 * r + 3));
    wr('{IDC_CMD_JUMPWR, 8'hA5});
    chk(jump, 8'hA5);
    rd('{IDC_CMD_REGRD | 8'h05}, '{8'h58, 8'hFF, 8'hFF});
    rd('{IDC_CMD_IDRD}, '{IDC_DEVICE_ID});
  endtask

  task automatic s_mem;
    wq = {};
    wr('{IDC_CMD_CWR, 8'h00, 8'h10, 8'h12, 8'h34, 8'h56, 8'h78});
    wr('{IDC_CMD_OWR, 8'h01, 8'h00, 8'h9A, 8'hBC, 8'hDE});
    wr('{IDC_CMD_PWR, 8'h00, 8'h20, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05});
    chk(wq.size(), 4);
    chk(wq[0], {2'h1, 16'h0010, 40'h1234});
    chk(wq[1], {2'h1, 16'h0011, 40'h5678});
    chk(wq[2], {2'h2, 16'h0100, 40'h9ABC});
    chk(wq[3], {2'h3, 16'h0020, 40'h0102030405});
  endtask

  // preparation precedes each execution, as the controller must do
  task automatic s_prep;
    wq = {};
    wr('{8'h81, 8'h00, 8'h20, 8'h11, 8'h11, 8'h22, 8'h22, 8'h33, 8'h33});
    wr('{IDC_CMD_OWPREP, 8'h00, 8'h30, 8'h44, 8'h44, 8'h55, 8'h55});
    wr('{IDC_CMD_CWEXEC, 8'h00, 8'h00});
    wr('{IDC_CMD_OWEXEC, 8'h00, 8'h00});
    chk(wq.size(), 3);
    chk(wq[1], {2'h1, 16'h0021, 40'h2222});
    chk(wq[2], {2'h2, 16'h0030, 40'h4444});
    chk(n_exc, 1);
    chk(n_exo, 1);
  endtask

  task automatic s_read;
    rd('{IDC_CMD_CRD, 8'h00, 8'h40}, '{8'hFF, 8'hBF, 8'hFF, 8'hBE});
    rd('{IDC_CMD_ORD, 8'h12, 8'h34}, '{8'hED, 8'hCB});
    rd('{IDC_CMD_PRD, 8'h00, 8'h07}, '{8'h00, 8'h07, 8'h5C, 8'hFF, 8'hF8});
    rb_a = 32'hABCDEF10;
    rb_b = 32'h1234567F;
    rd('{IDC_CMD_RBARD}, '{8'hAB, 8'hCD, 8'hEF, 8'h10});
    rd('{IDC_CMD_RBBRD}, '{8'h12, 8'h34, 8'h56, 8'h7F});
  endtask

  task automatic s_refuse;
    logic a;
    wq = {};
    u_idc_i2c_ctrl.start_c();
    u_idc_i2c_ctrl.send(WA ^ 8'h02, a);
    chk(a, 1'b0);
    u_idc_i2c_ctrl.stop_c();
    wr('{8'h00, 8'h11, 8'h22});
    sys_reset_in = 1'b0;
    wr('{IDC_CMD_CWR, 8'h00, 8'h50, 8'h12, 8'h34});
    u_idc_i2c_ctrl.start_c();
    u_idc_i2c_ctrl.send(WA, a);
    u_idc_i2c_ctrl.send(IDC_CMD_CRD, a);
    u_idc_i2c_ctrl.send(8'h00, a);
    u_idc_i2c_ctrl.send(8'h40, a);
    u_idc_i2c_ctrl.start_c();
    u_idc_i2c_ctrl.send(WA | 8'h01, a);
    chk(a, 1'b0);
    u_idc_i2c_ctrl.stop_c();
    sys_reset_in = 1'b1;
    chk(wq.size(), 0);
    chk(regs[0], 8'h03);
    u_idc_i2c_ctrl.start_c();
    u_idc_i2c_ctrl.send(WA | 8'h01, a);
    chk(a, 1'b0);
    u_idc_i2c_ctrl.stop_c();
    u_idc_i2c_ctrl.start_c();
    u_idc_i2c_ctrl.send(WA, a);
    u_idc_i2c_ctrl.send(IDC_CMD_REGRD, a);
    ready_in = 1'b1;
    u_idc_i2c_ctrl.start_c();
    u_idc_i2c_ctrl.send(WA | 8'h01, a);
    chk(a, 1'b0);
    u_idc_i2c_ctrl.stop_c();
    ready_in = 1'b0;
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // every partner step is a multiple of 40 ns, so stimulus stays on falling edges
  initial begin
    repeat (12) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rst_n_in = 1'b1;
    repeat (5) @(negedge core_clk_in);
    s_regs();
    s_mem();
    s_prep();
    s_read();
    s_refuse();
    give_verdict();
  end

  initial begin
    #900000;
    n_errors++;
    $display("[ERR] %0t run did not finish in time", $time);
    give_verdict();
  end
endmodule
